//--- bench/rsb_host_model.sv
// Controller model that feeds received bytes into the input buffer
`timescale 1ns/1ps
module rsb_host_model (
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic serial_mode,
    input wire logic [8:0] limit,
    input wire logic nrfd_hold,
    input wire logic send_xoff,
    input wire logic send_xon,
    output logic in_wr = 1'b0,
    output logic [7:0] in_data = 8'h00,
    output logic [8:0] sent = 9'h000
);
    logic paused = 1'b0; // Stopped by a stop character
    wire logic may_send; // Next byte may go out
    // Gaps between bytes let a hold raised by the last byte be seen in time
    assign may_send = !in_wr && sent < limit && !nrfd_hold && !(serial_mode && (paused || send_xoff));
    // Byte source, numbered in the order sent
    always @(posedge sys_clk) begin
        if (!nrst) begin
            in_wr <= 1'b0;
            paused <= 1'b0;
            sent <= 9'h000;
        end else begin
            // Pause on stop, resume on go
            if (send_xoff) paused <= 1'b1;
            else if (send_xon) paused <= 1'b0;
            in_wr <= may_send;
            // Idle data changes every cycle so stale bytes never look valid
            in_data <= may_send ? sent[7:0] : ~in_data;
            if (may_send) sent <= sent + 9'h001;
        end
    end
endmodule : rsb_host_model

//--- bench/rsb_status_bench.sv
// Self-checking bench for the status and buffer block
`timescale 1ns/1ps
module rsb_status_bench;
    import rsb_pkg::*;
    localparam int CEIL = 20000; // Cycle ceiling for the whole run
    logic sys_clk, nrst, serial, in_wr, resp_v, oq_v, oq_full, ib_v, nrfd, xoff, xon, v;
    logic [15:0] strb, dat, resp; // Request strobes, shared data, answer
    logic [8:0] limit, sent, ib_d, d;
    logic [7:0] in_data, oq_d, spb;
    int fail_count, n_compared, cycles, xoff_n, xon_n, got;
    int pos[5] = '{BIT_OPS_DONE, BIT_QUERY_ERR, BIT_DEVICE_ERR, BIT_EXEC_ERR, BIT_CMD_ERR}; // Bit of each strobe
    rsb_status rsb_status_inst (.sys_clk(sys_clk), .nrst(nrst), .ev_ops_done(strb[11]),
        .ev_query_err(strb[12]), .ev_device_err(strb[13]), .ev_exec_err(strb[14]), .ev_cmd_err(strb[15]),
        .err_code(dat[7:0]), .rd_event(strb[0]),
        .rd_mask(strb[1]), .fault_rd(strb[2]), .mask_wr(strb[3]), .mask_wr_data(dat), .clear_status(strb[4]),
        .reset_cmd(strb[5]), .dev_clear(strb[6]), .oq_wr(strb[7]), .oq_wr_data(dat[7:0]), .oq_rd(strb[8]),
        .in_wr(in_wr), .in_eoi(strb[9]), .in_data(in_data), .ib_rd(strb[10]), .resp_valid(resp_v),
        .resp_data(resp), .oq_rd_valid(oq_v), .oq_rd_data(oq_d), .oq_full(oq_full), .ib_rd_valid(ib_v),
        .ib_rd_data(ib_d), .serial_poll_byte(spb), .nrfd_hold(nrfd), .send_xoff(xoff), .send_xon(xon));
    rsb_host_model rsb_host_model_inst (.sys_clk(sys_clk), .nrst(nrst), .serial_mode(serial), .limit(limit),
        .nrfd_hold(nrfd), .send_xoff(xoff), .send_xon(xon), .in_wr(in_wr), .in_data(in_data), .sent(sent));
    // Counts, verdict and end of run
    task report_and_stop;
        $display("compared %0d, mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : report_and_stop
    // Compare one value
    task check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            fail_count++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    // One-cycle strobe; outputs of the taking edge are settled on return
    task pulse(input int i, input logic [15:0] val);
        @(posedge sys_clk);
        strb[i] <= 1'b1;
        dat <= val;
        @(posedge sys_clk);
        strb <= '0;
        #1;
    endtask : pulse
    // Register access with its answer
    task rd(input int i, input logic [15:0] exp);
        pulse(i, 16'h0000);
        check("resp_valid", {15'h0, resp_v}, 16'h0001);
        check("resp_data", resp, exp);
    endtask : rd
    // Take one input buffer entry
    task pop;
        pulse(10, 16'h0000);
        v = ib_v;
        d = ib_d;
    endtask : pop
    // Clock
    initial begin
        sys_clk = 1'b0;
        forever #25 sys_clk = ~sys_clk;
    end
    // Flow-control pulse tallies and hang guard
    always @(posedge sys_clk) begin
        cycles++;
        if (xoff === 1'b1) xoff_n++;
        if (xon === 1'b1) xon_n++;
        if (cycles == CEIL) begin
            fail_count++;
            report_and_stop();
        end
    end
    // Main sequence
    initial begin
        strb = '0;
        dat = '0;
        nrst = 1'b0;
        serial = 1'b0;
        limit = '0;
        repeat (20) @(posedge sys_clk);
        nrst <= 1'b1;
        rd(0, 16'h0080);
        rd(0, EVENT_RESET);
        rd(1, MASK_RESET);
        pulse(3, 16'hffff);
        rd(1, EV_VALID);
        rd(1, EV_VALID);
        $display("test registers done");
        // Each event lifts the summary and sticks until read
        for (int k = 0; k < 5; k++) begin
            pulse(11 + k, 16'h0000);
            check("summary", {15'h0, spb[SPB_SUMMARY]}, 16'h0001);
            repeat (3) @(posedge sys_clk);
            rd(0, 16'h0001 << pos[k]);
            check("summary", {15'h0, spb[SPB_SUMMARY]}, 16'h0000);
        end
        pulse(3, 16'h0000);
        pulse(12, 16'h0000);
        check("summary", {15'h0, spb[SPB_SUMMARY]}, 16'h0000);
        rd(0, 16'h0004);
        // Clear status, reset and device clear each wipe the events
        for (int c = 4; c < 7; c++) begin
            pulse(11, 16'h0000);
            pulse(c, 16'h0000);
            rd(0, EVENT_RESET);
        end
        rd(2, EQ_EMPTY_CODE);
        $display("test events done");
        // Error queue overrun keeps the oldest fifteen
        for (int i = 1; i < 18; i++) pulse(14, 16'(i));
        check("error flag", {15'h0, spb[SPB_ERROR]}, 16'h0001);
        rd(0, 16'h0010);
        for (int i = 1; i < 16; i++) rd(2, 16'(i));
        rd(2, {8'h00, EQ_OVERFLOW_CODE});
        rd(2, EQ_EMPTY_CODE);
        check("error flag", {15'h0, spb[SPB_ERROR]}, 16'h0000);
        check("poll byte", {8'h00, spb}, 16'h0000);
        $display("test error queue done");
        // Output queue filled past capacity, then drained in order
        for (int i = 0; i < 251; i++) pulse(7, 16'(i));
        check("oq_full", {15'h0, oq_full}, 16'h0001);
        check("message flag", {15'h0, spb[SPB_MESSAGE]}, 16'h0001);
        for (int i = 0; i < 251; i++) begin
            pulse(8, 16'h0000);
            check("oq read", {7'h0, oq_v, oq_v ? oq_d : 8'h00}, i < 250 ? {8'h01, 8'(i)} : 16'h0000);
        end
        check("message flag", {15'h0, spb[SPB_MESSAGE]}, 16'h0000);
        check("oq_full", {15'h0, oq_full}, 16'h0000);
        rd(0, 16'h0004);
        $display("test output queue done");
        // Parallel bus input held off when full
        @(posedge sys_clk);
        limit <= 9'd251;
        repeat (600) @(posedge sys_clk);
        #1;
        check("hold", {15'h0, nrfd}, 16'h0001);
        check("sent", {7'h0, sent}, {8'h00, IB_DEPTH});
        for (int i = 0; i < 251; i++) begin
            pop();
            check("ib read", {6'h0, v, d}, {7'h01, 9'(i)});
        end
        check("hold", {15'h0, nrfd}, 16'h0000);
        pulse(9, 16'h0000);
        pop();
        check("end marker", {6'h0, v, d}, {6'h0, 1'b1, EOI_MARK});
        pulse(9, 16'h0000);
        pulse(6, 16'h0000);
        pop();
        check("flush", {15'h0, v}, 16'h0000);
        $display("test parallel input done");
        // Serial link: host stops at the stop character, resumes on go
        xoff_n = 0;
        xon_n = 0;
        @(posedge sys_clk);
        serial <= 1'b1;
        limit <= 9'd501;
        repeat (600) @(posedge sys_clk);
        #1;
        check("stop count", 16'(xoff_n), 16'h0001);
        check("sent", {7'h0, sent}, 16'd251 + {8'h00, XOFF_LEVEL});
        got = 0;
        for (int n = 0; n < 2000 && got < 250; n++) begin
            pop();
            if (v === 1'b1) begin
                check("ib read", {7'h0, d}, 16'(251 + got) & 16'h00ff);
                got++;
            end
        end
        check("resume count", 16'(xon_n), 16'h0001);
        check("received", 16'(got), 16'd250);
        $display("test serial input done");
        report_and_stop();
    end
endmodule : rsb_status_bench

//--- shared/rsb_pkg.sv
// Constants shared by the remote status and buffer block
// Notes on behaviour
// - Mask bit one enables matching event bit
// - Summary bit set when any enabled event
// - Event bits stick until read or cleared
// - Event mask cleared at power-on
// - Sixteen-bit registers, unused bits read zero
// - Execution failure sets flag, queues error code
// - Device-specific command error sets device flag
// - Talk with nothing to send sets query flag
// - Event read clears; mask read does not
// - Read responses carry bits zero to fifteen
// - Query text enters 250-character output queue
// - Reads drain queue; empty queue gives nothing
// - Message flag follows output queue non-empty
// - Errors queued, but not query errors; fault read pops, zero if empty
// - Error queue emptied by power and clear-status
// - Keep fifteen errors, sixteenth is overflow code
// - Received bytes enter 250-byte input FIFO
// - Terminator end marker stored as own byte
// - Full input buffer holds ready-for-data off
// - Input buffer emptied by power and device clear
// - Stop at 80 percent, resume below 40
// - Event register cleared at power-on
// - Summary bit5, message bit4, error bit3
package rsb_pkg;
    localparam int EV_W = 16;                          // Event and mask width
    localparam logic [15:0] EV_VALID = 16'h00bd;       // Implemented event bits
    localparam logic [15:0] EVENT_RESET = 16'h0000;    // Event register at power-on
    localparam logic [15:0] MASK_RESET = 16'h0000;     // Mask at power-on
    localparam int BIT_OPS_DONE = 0;                   // Operations done
    localparam int BIT_QUERY_ERR = 2;                  // Query error
    localparam int BIT_DEVICE_ERR = 3;                 // Device error
    localparam int BIT_EXEC_ERR = 4;                   // Execution error
    localparam int BIT_CMD_ERR = 5;                    // Command error
    localparam int BIT_POWER_CYCLED = 7;               // Power cycled
    localparam int SPB_SUMMARY = 5;                    // Event summary position
    localparam int SPB_MESSAGE = 4;                    // Message waiting position
    localparam int SPB_ERROR = 3;                      // Error waiting position
    localparam logic [7:0] SPB_RESET = 8'h00;          // Poll byte at power-on
    localparam logic [7:0] OQ_DEPTH = 8'hfa;           // 250 characters
    localparam logic [7:0] IB_DEPTH = 8'hfa;           // 250 bytes
    localparam logic [4:0] EQ_KEEP = 5'h0f;            // Real errors kept
    localparam logic [4:0] EQ_SLOTS = 5'h10;           // Keep plus overflow slot
    localparam logic [7:0] EQ_OVERFLOW_CODE = 8'hff;   // Overflow entry code
    localparam logic [15:0] EQ_EMPTY_CODE = 16'h0000;  // Fault read of empty queue
    localparam int XOFF_PCT = 80;                      // Stop threshold, percent
    localparam int XON_PCT = 40;                       // Resume threshold, percent
    localparam logic [7:0] XOFF_LEVEL = 8'(250 * XOFF_PCT / 100);
    localparam logic [7:0] XON_LEVEL = 8'(250 * XON_PCT / 100);
    localparam logic [8:0] EOI_MARK = 9'h100;          // End marker entry
endpackage : rsb_pkg

//--- verilog/rsb_status.sv
// Status registers, error queue, output queue and input buffer
`timescale 1ns/1ps
module rsb_status (
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic ev_ops_done,
    input wire logic ev_query_err,
    input wire logic ev_device_err,
    input wire logic ev_exec_err,
    input wire logic ev_cmd_err,
    input wire logic [7:0] err_code,
    input wire logic rd_event,
    input wire logic rd_mask,
    input wire logic fault_rd,
    input wire logic mask_wr,
    input wire logic [rsb_pkg::EV_W-1:0] mask_wr_data,
    input wire logic clear_status,
    input wire logic reset_cmd,
    input wire logic dev_clear,
    input wire logic oq_wr,
    input wire logic [7:0] oq_wr_data,
    input wire logic oq_rd,
    input wire logic in_wr,
    input wire logic in_eoi,
    input wire logic [7:0] in_data,
    input wire logic ib_rd,
    output logic resp_valid,
    output logic [rsb_pkg::EV_W-1:0] resp_data,
    output logic oq_rd_valid,
    output logic [7:0] oq_rd_data,
    output logic oq_full,
    output logic ib_rd_valid,
    output logic [8:0] ib_rd_data,
    output logic [7:0] serial_poll_byte,
    output logic nrfd_hold,
    output logic send_xoff,
    output logic send_xon
);
    import rsb_pkg::*;

    // One-hot word for a set source at a bit position
    function automatic logic [15:0] bit_at(input int pos, input logic v);
        bit_at = 16'h0000;
        bit_at[pos] = v;
    endfunction : bit_at

    // Ring pointer step for the 250-deep stores
    function automatic logic [7:0] ring_next(input logic [7:0] p);
        ring_next = (p == OQ_DEPTH - 8'h01) ? 8'h00 : p + 8'h01;
    endfunction : ring_next

    logic [15:0] event_status;        // Sticky event bits
    logic [15:0] event_status_mask;   // Summary enables
    logic pwr_cycled_pend;            // Power cycled pending
    logic [7:0] oq_mem [0:249];       // Output characters
    logic [7:0] oq_wp, oq_rp, oq_cnt;
    logic [8:0] ib_mem [0:249];       // Input bytes and end markers
    logic [7:0] ib_wp, ib_rp, ib_cnt;
    logic [7:0] eq_mem [0:15];        // Error codes
    logic [3:0] eq_wp, eq_rp;
    logic [4:0] eq_cnt;
    logic xoff_state;                 // Sender told to stop

    // Request decode
    wire ev_clear = rd_event | dev_clear | reset_cmd | clear_status;
    wire err_push = ev_cmd_err | ev_exec_err | ev_device_err;
    wire fault_take = fault_rd & ~rd_event & ~rd_mask;
    wire oq_empty = (oq_cnt == 8'h00);
    wire oq_push = oq_wr & (oq_cnt != OQ_DEPTH);
    wire oq_pop = oq_rd & ~oq_empty;
    wire ib_push = (in_wr | in_eoi) & (ib_cnt != IB_DEPTH);
    wire ib_pop = ib_rd & (ib_cnt != 8'h00);
    wire [8:0] ib_wdata = in_eoi ? EOI_MARK : {1'b0, in_data};
    wire eq_pop = fault_take & (eq_cnt != 5'h00);
    wire eq_push = err_push & (eq_cnt != EQ_SLOTS);
    wire [7:0] eq_wdata = (eq_cnt == EQ_KEEP) ? EQ_OVERFLOW_CODE : err_code;

    // Event sources; an empty talk counts as a query error
    wire query_err_hit = ev_query_err | (oq_rd & oq_empty);
    wire [15:0] set_vec = bit_at(BIT_OPS_DONE, ev_ops_done) | bit_at(BIT_QUERY_ERR, query_err_hit)
        | bit_at(BIT_DEVICE_ERR, ev_device_err)
        | bit_at(BIT_EXEC_ERR, ev_exec_err)
        | bit_at(BIT_CMD_ERR, ev_cmd_err) | bit_at(BIT_POWER_CYCLED, pwr_cycled_pend);

    // Sets win over any clear in the same cycle
    wire [15:0] next_event = ((ev_clear ? 16'h0000 : event_status) | set_vec) & EV_VALID;
    wire [15:0] next_mask = mask_wr ? (mask_wr_data & EV_VALID) : event_status_mask;
    wire [7:0] next_oq_cnt = oq_cnt + 8'(oq_push) - 8'(oq_pop);
    wire [7:0] next_ib_cnt = dev_clear ? 8'h00 : ib_cnt + 8'(ib_push) - 8'(ib_pop);
    wire [4:0] next_eq_cnt = clear_status ? 5'h00 : eq_cnt + 5'(eq_push) - 5'(eq_pop);
    wire next_summary = |(next_event & next_mask);
    wire next_go_off = ~xoff_state & (next_ib_cnt >= XOFF_LEVEL);
    wire next_go_on = xoff_state & (next_ib_cnt < XON_LEVEL);

    // Poll byte assembly
    logic [7:0] next_spb;
    always_comb begin
        next_spb = SPB_RESET;
        next_spb[SPB_SUMMARY] = next_summary;
        next_spb[SPB_MESSAGE] = (next_oq_cnt != 8'h00);
        next_spb[SPB_ERROR] = (next_eq_cnt != 5'h00);
    end

    // Register read answers: event, mask, then fault query
    logic [15:0] next_resp;
    always_comb begin
        if (rd_event) begin
            next_resp = event_status;
        end else if (rd_mask) begin
            next_resp = event_status_mask;
        end else if (eq_pop) begin
            next_resp = {8'h00, eq_mem[eq_rp]};
        end else begin
            next_resp = EQ_EMPTY_CODE;
        end
    end

    // Event and mask registers
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            event_status <= EVENT_RESET;
            event_status_mask <= MASK_RESET;
            pwr_cycled_pend <= 1'b1;
        end else begin
            event_status <= next_event;
            event_status_mask <= next_mask;
            pwr_cycled_pend <= 1'b0;
        end
    end

    // Answer and poll byte outputs
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            resp_valid <= 1'b0;
            resp_data <= 16'h0000;
            serial_poll_byte <= SPB_RESET;
        end else begin
            resp_valid <= rd_event | rd_mask | fault_take;
            resp_data <= next_resp;
            serial_poll_byte <= next_spb;
        end
    end

    // Output queue storage, no reset needed
    always_ff @(posedge sys_clk) begin
        if (oq_push) begin
            oq_mem[oq_wp] <= oq_wr_data;
        end
    end

    // Output queue pointers; empty read stays silent
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            oq_wp <= 8'h00;
            oq_rp <= 8'h00;
            oq_cnt <= 8'h00;
            oq_full <= 1'b0;
            oq_rd_valid <= 1'b0;
            oq_rd_data <= 8'h00;
        end else begin
            oq_wp <= oq_push ? ring_next(oq_wp) : oq_wp;
            oq_rp <= oq_pop ? ring_next(oq_rp) : oq_rp;
            oq_cnt <= next_oq_cnt;
            oq_full <= (next_oq_cnt == OQ_DEPTH);
            oq_rd_valid <= oq_pop;
            oq_rd_data <= oq_pop ? oq_mem[oq_rp] : 8'h00;
        end
    end

    // Input buffer storage
    always_ff @(posedge sys_clk) begin
        if (ib_push) begin
            ib_mem[ib_wp] <= ib_wdata;
        end
    end

    // Input buffer pointers, bus hold and flow control
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            ib_wp <= 8'h00;
            ib_rp <= 8'h00;
            ib_cnt <= 8'h00;
            ib_rd_valid <= 1'b0;
            ib_rd_data <= 9'h000;
            nrfd_hold <= 1'b0;
            xoff_state <= 1'b0;
            send_xoff <= 1'b0;
            send_xon <= 1'b0;
        end else begin
            ib_wp <= dev_clear ? 8'h00 : (ib_push ? ring_next(ib_wp) : ib_wp);
            ib_rp <= dev_clear ? 8'h00 : (ib_pop ? ring_next(ib_rp) : ib_rp);
            ib_cnt <= next_ib_cnt;
            ib_rd_valid <= ib_pop;
            ib_rd_data <= ib_pop ? ib_mem[ib_rp] : 9'h000;
            nrfd_hold <= (next_ib_cnt == IB_DEPTH);
            xoff_state <= next_go_off | (xoff_state & ~next_go_on);
            send_xoff <= next_go_off;
            send_xon <= next_go_on;
        end
    end

    // Error queue storage; slot after fifteen gets overflow code
    always_ff @(posedge sys_clk) begin
        if (eq_push) begin
            eq_mem[eq_wp] <= eq_wdata;
        end
    end

    // Error queue pointers; later errors dropped once full
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            eq_wp <= 4'h0;
            eq_rp <= 4'h0;
            eq_cnt <= 5'h00;
        end else if (clear_status) begin
            eq_wp <= 4'h0;
            eq_rp <= 4'h0;
            eq_cnt <= 5'h00;
        end else begin
            eq_wp <= eq_push ? eq_wp + 4'h1 : eq_wp;
            eq_rp <= eq_pop ? eq_rp + 4'h1 : eq_rp;
            eq_cnt <= next_eq_cnt;
        end
    end

    // Checks
    sequence s_fill;
        !xoff_state ##1 (ib_cnt >= XOFF_LEVEL);
    endsequence
    sequence s_drain;
        xoff_state ##1 (ib_cnt < XON_LEVEL);
    endsequence

    chk_power_clear: assert property (@(posedge sys_clk) disable iff (!nrst)
        $past(nrst) == 1'b0 |-> event_status_mask == 16'h0000 && event_status == 16'h0000)
        else $error("Mask or event not clear after power-on");
    chk_summary_bit: assert property (@(posedge sys_clk) disable iff (!nrst)
        serial_poll_byte[SPB_SUMMARY] == |(event_status & event_status_mask))
        else $error("Summary bit disagrees with enabled events");
    chk_event_sticky: assert property (@(posedge sys_clk) disable iff (!nrst)
        !ev_clear |=> (event_status & $past(event_status)) == $past(event_status))
        else $error("Event bit dropped without a clear");
    chk_event_read: assert property (@(posedge sys_clk) disable iff (!nrst)
        rd_event && set_vec == 16'h0000 |=> resp_valid && resp_data == $past(event_status)
        && event_status == 16'h0000)
        else $error("Event read did not return and clear");
    chk_unused_zero: assert property (@(posedge sys_clk) disable iff (!nrst)
        ((event_status | event_status_mask) & ~EV_VALID) == 16'h0000)
        else $error("Unused event bit is set");
    chk_exec_queued: assert property (@(posedge sys_clk) disable iff (!nrst)
        ev_exec_err && eq_cnt < EQ_KEEP && !fault_rd && !clear_status
        |=> event_status[BIT_EXEC_ERR] && eq_cnt == $past(eq_cnt) + 5'h01)
        else $error("Execution error not recorded");
    chk_message_flag: assert property (@(posedge sys_clk) disable iff (!nrst)
        serial_poll_byte[SPB_MESSAGE] == (oq_cnt != 8'h00))
        else $error("Message flag disagrees with output queue");
    chk_empty_talk: assert property (@(posedge sys_clk) disable iff (!nrst)
        oq_rd && oq_cnt == 8'h00 |=> !oq_rd_valid && event_status[BIT_QUERY_ERR])
        else $error("Empty output queue read misbehaved");
    chk_queue_cap: assert property (@(posedge sys_clk) disable iff (!nrst)
        err_push && eq_cnt == EQ_SLOTS && !fault_rd && !clear_status |=> eq_cnt == EQ_SLOTS)
        else $error("Error accepted past overflow slot");
    chk_fault_empty: assert property (@(posedge sys_clk) disable iff (!nrst)
        fault_take && eq_cnt == 5'h00 |=> resp_valid && resp_data == 16'h0000)
        else $error("Empty fault read not zero");
    chk_bus_hold: assert property (@(posedge sys_clk) disable iff (!nrst)
        nrfd_hold == (ib_cnt == IB_DEPTH))
        else $error("Ready hold disagrees with full buffer");
    chk_flow_stop: assert property (@(posedge sys_clk) disable iff (!nrst)
        s_fill |-> send_xoff)
        else $error("Stop character missing at high level");
    chk_flow_go: assert property (@(posedge sys_clk) disable iff (!nrst)
        s_drain |-> send_xon)
        else $error("Resume character missing at low level");
    chk_buffer_flush: assert property (@(posedge sys_clk) disable iff (!nrst)
        dev_clear |=> ib_cnt == 8'h00)
        else $error("Device clear left input bytes");
endmodule : rsb_status
